// >>> core/flash_protect_regs.vh
`ifndef FLASH_PROTECT_REGS_VH
`define FLASH_PROTECT_REGS_VH

// command codes, one byte each
`define CMD_WRITE_ENABLE 8'h06
`define CMD_WRITE_DISABLE 8'h04
`define CMD_READ_STATUS 8'h05
`define CMD_PROTECT_MAP_WRITE 8'h42
`define CMD_PROTECT_MAP_READ 8'h72
`define CMD_GLOBAL_UNPROTECT 8'h98
`define CMD_NV_LOCKDOWN 8'he8
`define CMD_DEEP_SLEEP_ENTRY 8'hb9
`define CMD_DEEP_SLEEP_RELEASE 8'hab

// protection map layout and values
`define MAP_RESET 48'h5555ffffffff
`define WRITE_LOCK_MASK 48'h5555ffffffff
`define OVERLAY_LOW_BIT 6'd30
`define OVERLAY_HIGH_BIT 6'd31
`define PARAM_BOTTOM_BASE 6'd32
`define PARAM_TOP_BASE 6'd40

// frame bit positions, counted in rising serial clock edges
`define CMD_BITS 7'd8
`define MAP_FRAME_BITS 7'd56
`define ID_START_BITS 7'd11
`define MAP_LAST_BIT 7'd55

// status byte fields
`define STATUS_BUSY_BIT 0
`define STATUS_WEL_BIT 1

// timing, times in ns, counts in core clock cycles
`define CLK_PERIOD_NS 21'd4
`define SLEEP_ENTRY_DELAY_NS 21'd3000
`define WAKE_READY_DELAY_NS 21'd10000
// pin synchroniser lag, taken off both delays so they hold at the pins
`define SYNC_LAG_CYCLES 21'd8
`define NV_PROG_TIME_NS 21'd1500000
`define SLEEP_ENTRY_CYCLES (`SLEEP_ENTRY_DELAY_NS / `CLK_PERIOD_NS)
`define WAKE_READY_CYCLES (`WAKE_READY_DELAY_NS / `CLK_PERIOD_NS)
`define NV_PROG_CYCLES_DEF (`NV_PROG_TIME_NS / `CLK_PERIOD_NS)

`endif

// >>> core/flash_block_protect_deep_sleep.v
`timescale 1ns/1ns
`default_nettype none
`include "flash_protect_regs.vh"

module flash_block_protect_deep_sleep #(
  parameter [20:0] NV_PROG_CYCLES = `NV_PROG_CYCLES_DEF,
  parameter [7:0] DEVICE_ID = 8'h5a // arbitrary value
) (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // serial pins
  input wire csN,
  input wire sck,
  input wire mosi,
  output reg miso,
  output reg misoOe,
  // array side
  input wire writeBusy,
  input wire supplyOk,
  input wire [20:0] checkAddr,
  output reg writeBlocked,
  output reg readBlocked,
  // state view
  output reg deepSleep,
  output reg deviceBusy,
  output reg [47:0] protectMap
);

  // one-hot power states
  localparam [4:0] ST_STANDBY = 5'b00001;
  localparam [4:0] ST_ENTERING = 5'b00010;
  localparam [4:0] ST_SLEEP = 5'b00100;
  localparam [4:0] ST_WAKING = 5'b01000;
  localparam [4:0] ST_NVPROG = 5'b10000;

  // read kinds chosen at command completion
  localparam [1:0] RD_NONE = 2'd0;
  localparam [1:0] RD_STATUS = 2'd1;
  localparam [1:0] RD_MAP = 2'd2;
  localparam [1:0] RD_ID = 2'd3;

  // pin synchronisers, stage one read only by stage two
  reg [2:0] csSync;
  reg [2:0] sckSync;
  reg [1:0] mosiSync;
  // frame capture
  reg [6:0] bitCnt; // rising edges since select, saturates
  reg [7:0] cmdReg; // command byte of this frame
  reg cmdDone; // command byte complete
  reg [47:0] dataIn; // data bits after the command
  reg [1:0] readKind; // what the output stream carries
  // control state
  reg [4:0] state;
  reg [20:0] timer; // shared delay counter
  reg wel; // write-enable latch
  reg [47:0] lockdown; // set-once lockdown bits
  // decode of the address under check
  reg [5:0] wIdx;
  reg hasRead;
  reg [5:0] rIdx;

  // synced views and edges
  wire csS = csSync[1];
  wire csRise = csSync[1] & ~csSync[2];
  wire csFall = ~csSync[1] & csSync[2];
  wire sckRise = sckSync[1] & ~sckSync[2] & ~csS;
  wire sckFall = ~sckSync[1] & sckSync[2] & ~csS;
  wire mosiS = mosiSync[1];
  wire [7:0] cmdNow = {cmdReg[6:0], mosiS};
  // lockdown bits only ever sit on write-lock positions
  wire [47:0] lockedWr = lockdown & `WRITE_LOCK_MASK;
  wire busyAny = writeBusy | state[4];
  wire [7:0] statusByte = {6'h00, wel, busyAny};
  wire mapFrame = (bitCnt >= `MAP_FRAME_BITS);
  wire [47:0] mapWrMask = `WRITE_LOCK_MASK;

  // bit select helpers for the output stream
  wire [2:0] statIdx = 3'd7 - bitCnt[2:0];
  wire [6:0] idOff = bitCnt - `ID_START_BITS;
  wire [2:0] idIdx = 3'd7 - idOff[2:0];
  wire [6:0] mapOff = `MAP_LAST_BIT - bitCnt;

  // two flip-flops on every pin before any logic looks
  always @(posedge core_clk) begin
    if (rst) begin
      csSync <= 3'b111;
      sckSync <= 3'b000;
      mosiSync <= 2'b00;
    end else begin
      csSync <= {csSync[1:0], csN};
      sckSync <= {sckSync[1:0], sck};
      mosiSync <= {mosiSync[0], mosi};
    end
  end

  // frame capture: command byte then data, MSB first
  always @(posedge core_clk) begin
    if (rst || csFall) begin
      // a new frame clears the previous one
      bitCnt <= 7'd0;
      cmdReg <= 8'h00;
      cmdDone <= 1'b0;
      dataIn <= 48'h000000000000;
    end else if (sckRise) begin
      if (bitCnt != 7'h7f) begin
        bitCnt <= bitCnt + 7'd1;
      end
      if (bitCnt < `CMD_BITS) begin
        cmdReg <= cmdNow;
      end
      if (bitCnt == `CMD_BITS - 7'd1) begin
        cmdDone <= 1'b1;
      end
      // surplus bits beyond the map are dropped
      if (bitCnt >= `CMD_BITS && bitCnt < `MAP_FRAME_BITS) begin
        dataIn <= {dataIn[46:0], mosiS};
      end
    end
  end

  // pick the read stream when the command byte lands
  always @(posedge core_clk) begin
    if (rst || csFall) begin
      readKind <= RD_NONE;
    end else if (sckRise && bitCnt == `CMD_BITS - 7'd1) begin
      if (!supplyOk) begin
        readKind <= RD_NONE;
      end else if (state[2]) begin
        // asleep: only the release may answer
        readKind <= (cmdNow == `CMD_DEEP_SLEEP_RELEASE) ? RD_ID :
                    RD_NONE;
      end else if (state[4]) begin
        // lockdown programming: status polls only
        readKind <= (cmdNow == `CMD_READ_STATUS) ? RD_STATUS :
                    RD_NONE;
      end else if (state[0]) begin
        case (cmdNow)
          `CMD_READ_STATUS: begin
            readKind <= RD_STATUS;
          end
          `CMD_PROTECT_MAP_READ: begin
            readKind <= RD_MAP;
          end
          `CMD_DEEP_SLEEP_RELEASE: begin
            readKind <= RD_ID;
          end
          default: begin
            readKind <= RD_NONE;
          end
        endcase
      end else begin
        readKind <= RD_NONE; // entering or waking: deaf
      end
    end
  end

  // output stream, updated on falling serial clock edges
  always @(posedge core_clk) begin
    if (rst || csS || !supplyOk) begin // parked while idle
      miso <= 1'b0;
      misoOe <= 1'b0;
    end else if (sckFall && cmdDone) begin
      case (readKind)
        RD_STATUS: begin
          miso <= statusByte[statIdx];
          misoOe <= 1'b1;
        end
        RD_MAP: begin
          // zeros once the last map bit has gone
          miso <= (bitCnt <= `MAP_LAST_BIT) ? protectMap[mapOff[5:0]] :
                  1'b0;
          misoOe <= 1'b1;
        end
        RD_ID: begin
          // ID repeats until the bit count saturates, after dummy clocks
          miso <= (bitCnt >= `ID_START_BITS) & DEVICE_ID[idIdx];
          misoOe <= (bitCnt >= `ID_START_BITS);
        end
        default: begin
          miso <= 1'b0;
          misoOe <= 1'b0;
        end
      endcase
    end
  end

  // power state, map, latch and lockdown, acting on deselect
  always @(posedge core_clk) begin
    if (rst) begin
      state <= ST_STANDBY;
      timer <= 21'd0;
      wel <= 1'b0;
      lockdown <= 48'h000000000000;
      protectMap <= `MAP_RESET;
    end else begin
      if (timer != 21'd0) begin
        timer <= timer - 21'd1;
      end
      case (state)
        ST_STANDBY: begin
          if (csRise && cmdDone && supplyOk) begin
            case (cmdReg)
              `CMD_WRITE_ENABLE: begin
                wel <= 1'b1;
              end
              `CMD_WRITE_DISABLE: begin
                wel <= wel & busyAny; // a running write keeps it
              end
              `CMD_PROTECT_MAP_WRITE: begin
                // locked write bits stay set whatever is sent
                if (wel && mapFrame && !busyAny) begin
                  protectMap <= dataIn | lockedWr;
                  wel <= 1'b0;
                end
              end
              `CMD_GLOBAL_UNPROTECT: begin
                if (wel && !busyAny) begin
                  protectMap <= (protectMap & ~mapWrMask) | lockedWr;
                  wel <= 1'b0;
                end
              end
              `CMD_NV_LOCKDOWN: begin
                // set-only: no command clears a one, only reset does
                if (wel && mapFrame && !busyAny) begin
                  lockdown <= lockdown | (dataIn & mapWrMask);
                  protectMap <= protectMap | (dataIn & mapWrMask);
                  wel <= 1'b0;
                  timer <= NV_PROG_CYCLES;
                  state <= ST_NVPROG;
                end
              end
              `CMD_DEEP_SLEEP_ENTRY: begin
                // a busy array keeps the device awake
                if (!busyAny) begin
                  timer <= `SLEEP_ENTRY_CYCLES - `SYNC_LAG_CYCLES;
                  state <= ST_ENTERING;
                end
              end
              default: begin
              end
            endcase
          end
        end
        ST_ENTERING: begin
          if (timer == 21'd1) begin
            state <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          // nothing but the release wakes the device
          if (csRise && cmdDone && supplyOk &&
              cmdReg == `CMD_DEEP_SLEEP_RELEASE) begin
            timer <= `WAKE_READY_CYCLES - `SYNC_LAG_CYCLES;
            state <= ST_WAKING;
          end
        end
        ST_WAKING, ST_NVPROG: begin
          // wake delay or lockdown programming has run out
          if (timer == 21'd1) begin
            state <= ST_STANDBY;
          end
        end
        default: begin
          state <= ST_STANDBY;
        end
      endcase
    end
  end

  // address to map bit: overlays and parameter pairs at the ends
  always @* begin
    wIdx = 6'd0;
    hasRead = 1'b0;
    rIdx = 6'd0;
    case (checkAddr[20:16])
      5'h00: begin
        if (checkAddr[15]) begin
          wIdx = `OVERLAY_LOW_BIT;
        end else begin
          wIdx = `PARAM_BOTTOM_BASE + {3'b000, checkAddr[14:13], 1'b0};
          hasRead = 1'b1;
        end
      end
      5'h1f: begin
        if (!checkAddr[15]) begin
          wIdx = `OVERLAY_HIGH_BIT;
        end else begin
          wIdx = `PARAM_TOP_BASE + {3'b000, checkAddr[14:13], 1'b0};
          hasRead = 1'b1;
        end
      end
      default: begin
        wIdx = {1'b0, checkAddr[20:16]} - 6'd1;
      end
    endcase
    rIdx = wIdx | 6'd1; // read lock is the odd neighbour
  end

  // registered protection answers and state view
  always @(posedge core_clk) begin
    if (rst) begin
      writeBlocked <= 1'b1;
      readBlocked <= 1'b0;
      deepSleep <= 1'b0;
      deviceBusy <= 1'b0;
    end else begin
      writeBlocked <= protectMap[wIdx] | lockedWr[wIdx];
      readBlocked <= hasRead & protectMap[rIdx];
      deepSleep <= state[2];
      deviceBusy <= busyAny;
    end
  end

endmodule
`default_nettype wire

// >>> tb/flash_protect_props.sv
`timescale 1ns/1ns
`default_nettype none
`include "flash_protect_regs.vh"
module flash_protect_props (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // serial pins
  input wire logic csN,
  input wire logic sck,
  input wire logic miso,
  input wire logic misoOe,
  // array side
  input wire logic writeBusy,
  input wire logic supplyOk,
  input wire logic [20:0] checkAddr,
  input wire logic writeBlocked,
  input wire logic readBlocked,
  // state view
  input wire logic deepSleep,
  input wire logic deviceBusy,
  input wire logic [47:0] protectMap
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  logic [11:0] sinceCs; // cycles since deselect, saturating
  wire mapBit = protectMap[checkAddr[20:16] - 5'h1]; // big block lock
  // saturate so a long idle never wraps into a false pass
  always_ff @(posedge core_clk) begin
    if (rst || !csN)
      sinceCs <= 12'h0;
    else if (sinceCs != 12'hfff)
      sinceCs <= sinceCs + 12'h1;
  end
  sequence idleCs;
    csN[*6];
  endsequence
  sequence noSupply;
    !supplyOk[*4];
  endsequence
  reset_map_a: assert property ($fell(rst) |->
    protectMap == `MAP_RESET && !misoOe && !deepSleep)
    else $error("state not at reset value");
  oe_release_a: assert property (idleCs |-> !misoOe)
    else $error("output held after deselect");
  supply_off_a: assert property (noSupply |-> !misoOe)
    else $error("output driven on low supply");
  miso_edge_a: assert property ($changed(miso) |-> !sck)
    else $error("output moved while clock high");
  sleep_map_a: assert property (
    deepSleep && $past(deepSleep) |-> $stable(protectMap))
    else $error("map changed while asleep");
  sleep_entry_a: assert property (
    $rose(deepSleep) |-> csN && sinceCs <= 12'd749)
    else $error("sleep entry late or mid frame");
  wake_cs_a: assert property ($fell(deepSleep) |-> csN)
    else $error("wake before deselect");
  busy_track_a: assert property (
    writeBusy |-> ##[0:1] deviceBusy)
    else $error("busy not reflected");
  big_lock_a: assert property (
    $past(checkAddr[20:16]) inside {[5'd1:5'd30]} && $past(mapBit)
    |-> writeBlocked)
    else $error("locked block not blocked");
  read_lock_a: assert property (readBlocked |->
    $past(checkAddr) < 21'h008000 || $past(checkAddr) >= 21'h1f8000)
    else $error("read lock outside parameter block");
endmodule
bind flash_block_protect_deep_sleep flash_protect_props chk (
  .core_clk, .rst, .csN, .sck, .miso, .misoOe, .writeBusy,
  .supplyOk, .checkAddr, .writeBlocked, .readBlocked, .deepSleep,
  .deviceBusy, .protectMap);
`default_nettype wire

// >>> tb/spi_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// host side: mode 0 frames, clock still between frames
module spi_host_model (
  // clock
  input wire logic core_clk,
  // serial pins
  output logic csN,
  output logic sck,
  output logic mosi,
  input wire logic miso,
  input wire logic misoOe
);
  logic [63:0] rx; // bits caught at clock rise
  logic sawOe; // device drove during the frame
  initial begin
    csN = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
    rx = 64'h0;
    sawOe = 1'b0;
  end
  // note any drive by the device
  always @(posedge core_clk) begin
    if (misoOe)
      sawOe <= 1'b1;
  end
  // command byte then n clocks of data, data bit 47 first
  task automatic frame(input logic [7:0] c, input logic [47:0] d,
                       input int n);
    sawOe = 1'b0;
    csN = 1'b0;
    #63;
    for (int i = 0; i < 8 + n; i++) begin
      mosi = (i < 8) ? c[7 - i] : d[55 - i];
      #62 sck = 1'b1;
      rx = {rx[62:0], miso};
      #63 sck = 1'b0;
    end
    #62 csN = 1'b1;
    mosi = ~mosi; // released line shows no stale level
    #250;
  endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "flash_protect_regs.vh"
module testbench;
  localparam logic [7:0] ID = 8'h3c; // arbitrary value
  localparam int NVC = 4000; // shortened lockdown time
  localparam logic [47:0] MAP = 48'h4209a0000001; // mixed locks
  localparam logic [47:0] LK = 48'h020800000020; // after lockdown
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic writeBusy = 1'b0;
  logic supplyOk = 1'b1;
  logic [20:0] checkAddr = 21'h0;
  wire csN, sck, mosi, miso, misoOe, writeBlocked, readBlocked;
  wire deepSleep, deviceBusy;
  wire [47:0] protectMap;
  int fails = 0;
  int total_checks = 0;
  // address, expected write block, expected read block
  logic [22:0] rows [10] = '{{21'h010000, 2'b10}, {21'h020000, 2'b00},
    {21'h1effff, 2'b10}, {21'h008000, 2'b00}, {21'h1f7fff, 2'b10},
    {21'h000000, 2'b10}, {21'h002000, 2'b01}, {21'h1fe000, 2'b10},
    {21'h1f8000, 2'b01}, {21'h1fc000, 2'b00}};
  always #2 core_clk = ~core_clk;
  spi_host_model host (.core_clk, .csN, .sck, .mosi, .miso, .misoOe);
  flash_block_protect_deep_sleep #(.NV_PROG_CYCLES(21'd4000),
    .DEVICE_ID(ID)) uut (.core_clk, .rst, .csN, .sck, .mosi, .miso,
    .misoOe, .writeBusy, .supplyOk, .checkAddr, .writeBlocked,
    .readBlocked, .deepSleep, .deviceBusy, .protectMap);
  task chk(input logic [47:0] got, input logic [47:0] exp,
           input string m);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // a frame ends off the clock grid; get back onto a falling edge
  task fr(input logic [7:0] c, input logic [47:0] d, input int n);
    host.frame(c, d, n);
    cyc(1);
  endtask
  task cmd(input logic [7:0] c);
    fr(c, 48'h0, 0);
  endtask
  task rd;
    fr(`CMD_PROTECT_MAP_READ, 48'h0, 48);
  endtask
  task wr(input logic [47:0] v);
    cmd(`CMD_WRITE_ENABLE);
    fr(`CMD_PROTECT_MAP_WRITE, v, 48);
  endtask
  task summarize;
    if (fails == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial begin
    #200000;
    fails++;
    $display("BAD %0t timeout", $time);
    summarize();
  end
  initial begin
    cyc(5);
    rst = 1'b0;
    cyc(3);
    chk(protectMap, `MAP_RESET, "reset map");
    fr(`CMD_PROTECT_MAP_READ, 48'h0, 56);
    chk(host.rx[55:8], `MAP_RESET, "map read");
    chk(host.rx[7:0], 8'h00, "zeros after map");
    wr(MAP);
    chk(protectMap, MAP, "map write");
    for (int i = 0; i < 10; i++) begin
      checkAddr = rows[i][22:2];
      cyc(2);
      chk({writeBlocked, readBlocked}, rows[i][1:0], "class");
    end
    fr(`CMD_PROTECT_MAP_WRITE, 48'h0, 48);
    chk(protectMap, MAP, "write without enable");
    cmd(`CMD_WRITE_ENABLE);
    cmd(`CMD_GLOBAL_UNPROTECT);
    chk(protectMap, MAP & ~`WRITE_LOCK_MASK, "unlock");
    cmd(`CMD_WRITE_ENABLE);
    fr(`CMD_NV_LOCKDOWN, 48'h20, 48);
    rd();
    chk(host.sawOe, 1'b0, "read while programming");
    fr(`CMD_READ_STATUS, 48'h0, 8);
    chk(host.rx[7:0], 8'h01, "status while programming");
    for (int i = 0; i < NVC && deviceBusy !== 1'b0; i++)
      cyc(1);
    chk(deviceBusy, 1'b0, "lockdown done");
    cmd(`CMD_WRITE_ENABLE);
    cmd(`CMD_GLOBAL_UNPROTECT);
    chk(protectMap, LK, "locked bit survives");
    checkAddr = 21'h060000;
    cyc(2);
    chk(writeBlocked, 1'b1, "locked block");
    writeBusy = 1'b1;
    cmd(`CMD_DEEP_SLEEP_ENTRY);
    cyc(700);
    chk(deepSleep, 1'b0, "entry while busy");
    writeBusy = 1'b0;
    cmd(`CMD_DEEP_SLEEP_ENTRY);
    cyc(700);
    chk(deepSleep, 1'b1, "sleep entry");
    wr(MAP);
    rd();
    chk(host.sawOe, 1'b0, "read while asleep");
    cmd(`CMD_DEEP_SLEEP_RELEASE);
    rd();
    chk(host.sawOe, 1'b0, "read during wake");
    cyc(2600);
    chk(deepSleep, 1'b0, "release");
    rd();
    chk(host.rx[47:0], LK, "read after wake");
    fr(`CMD_DEEP_SLEEP_RELEASE, 48'h0, 11);
    chk(host.rx[7:0], ID, "id read");
    supplyOk = 1'b0;
    cyc(8);
    rd();
    chk(host.sawOe, 1'b0, "low supply");
    supplyOk = 1'b1;
    rst = 1'b1;
    cyc(5);
    rst = 1'b0;
    cyc(3);
    chk(protectMap, `MAP_RESET, "second reset");
    summarize();
  end
endmodule
`default_nettype wire
